// ===== hbh_pkg.sv
// shared constants for the host bus handshake and decode block
package hbh_pkg;
    // address decode
    localparam int          ADDR_W          = 12;      // upper address lines, bits 4..15
    localparam int          BASE_W          = 8;       // base address high byte
    localparam logic [3:0]  BASE_LOW_NIBBLE = 4'h0;    // lines 4..7 must read zero to match
    localparam int          BE_W            = 4;       // byte lanes of the 32-bit data bus
    localparam logic [3:0]  BE_ALL          = 4'hf;    // every lane active, full 32 bits
    localparam logic [3:0]  BE_NONE         = 4'h0;    // reset value of the lane outputs
    // fifo thresholds
    localparam int          FIFO_LVL_W      = 4;       // width of read fifo byte count
    localparam logic [3:0]  RD_MIN_BYTES    = 4'h4;    // a read needs this many bytes buffered
    // local bus clock limits, kept by the host
    localparam real         LOCAL_BUS_CLOCK_MAX_MHZ    = 50.0;
    localparam real         LOCAL_BUS_CLOCK_EISA_MHZ   = 8.33;
    // width of the pin bundle synchronised into the core clock
    localparam int          PIN_SYNC_W      = 22;
endpackage

// ===== hbh_sync2.sv
// two flip-flop level synchroniser for a bundle of bits
`timescale 1ns/100ps
`default_nettype none
module hbh_sync2 #(
    parameter int          WIDTH    = 1,
    parameter logic        INIT_VAL = 1'b0
) (
    // clock and reset of the receiving domain
    input  wire logic             clk,
    input  wire logic             reset_n,
    // levels from the other domain
    input  wire logic [WIDTH-1:0] async_in,
    // levels safe to use here
    output logic      [WIDTH-1:0] sync_out
);
    // both stages in one struct; stage one feeds stage two only
    typedef struct packed {
        logic [WIDTH-1:0] meta;    // may go metastable
        logic [WIDTH-1:0] stable;  // settled copy
    } hbh_sync_state_t;

    hbh_sync_state_t s_q;
    hbh_sync_state_t s_d;

    // next state: shift the bundle by one stage
    always_comb begin
        s_d        = s_q;
        s_d.meta   = async_in;
        s_d.stable = s_q.meta;
    end

    // registers, reset to the idle level of the pins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= {2{{WIDTH{INIT_VAL}}}};
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.stable;
endmodule
`default_nettype wire

// ===== hbh_local_bus_clock_ready.sv
// synchronous ready logic that runs on the local bus clock
`timescale 1ns/100ps
`default_nettype none
module hbh_local_bus_clock_ready (
    // local bus clock domain
    input  wire logic local_bus_clock,
    input  wire logic reset_n,
    // host cycle pins, synchronous to the local bus clock
    input  wire logic address_latch_strobe_n,
    input  wire logic cycle_sel_n,
    input  wire logic cycle_is_write,
    input  wire logic ready_return_n,
    input  wire logic vl_mode_select_n,
    // levels from the core clock domain
    input  wire logic core_rd_ok,
    input  wire logic core_wr_ok,
    // completion output to the host
    output logic      sync_ready_n
);
    // cycle states
    typedef enum logic [1:0] {HBH_SY_IDLE, HBH_SY_WAIT, HBH_SY_DONE} hbh_sy_state_t;

    typedef struct packed {
        hbh_sy_state_t st;      // cycle progress
        logic          srdy_n;  // registered ready output
    } hbh_local_bus_clock_state_t;

    hbh_local_bus_clock_state_t s_q;
    hbh_local_bus_clock_state_t s_d;
    logic [2:0]      lvl_s;      // core levels and mode strap after crossing
    logic            rtn_fall_q; // ready return taken on the falling edge
    logic            go_ok;

    // core levels and the strap pass two flops in this domain
    hbh_sync2 #(.WIDTH(3), .INIT_VAL(1'b0)) u_sync_core (
        .clk      (local_bus_clock),
        .reset_n  (reset_n),
        .async_in ({vl_mode_select_n, core_wr_ok, core_rd_ok}),
        .sync_out (lvl_s)
    );

    // ready return is sampled on falling local clock edges
    always_ff @(negedge local_bus_clock or negedge reset_n) begin
        if (!reset_n) begin
            rtn_fall_q <= 1'b0;
        end else begin
            rtn_fall_q <= ready_return_n;
        end
    end

    // data side ready for the direction of this cycle
    assign go_ok = cycle_is_write ? lvl_s[1] : lvl_s[0];

    // cycle sequencing
    always_comb begin
        s_d = s_q;
        case (s_q.st)
            HBH_SY_IDLE: begin
                s_d.srdy_n = 1'b1;
                if (!address_latch_strobe_n && !cycle_sel_n) begin
                    s_d.st = HBH_SY_WAIT;
                end
            end
            HBH_SY_WAIT: begin
                // eisa burst stalls until ready return is seen high
                if (go_ok && (!lvl_s[2] || rtn_fall_q)) begin
                    s_d.st     = HBH_SY_DONE;
                    // only vl mode pulls the ready low; eisa keeps it high
                    s_d.srdy_n = lvl_s[2];
                end
            end
            HBH_SY_DONE: begin
                s_d.srdy_n = 1'b1;
                s_d.st     = HBH_SY_IDLE;
            end
            default: begin
                s_d.st     = HBH_SY_IDLE;
                s_d.srdy_n = 1'b1;
            end
        endcase
    end

    // state registers; the falling ready edge is made on this clock
    always_ff @(posedge local_bus_clock or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '{st: HBH_SY_IDLE, srdy_n: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_ready_n = s_q.srdy_n;

    // eisa mode never drives the ready low
    AST_SRDY_EISA_HIGH: assert property (@(posedge local_bus_clock) disable iff (!reset_n)
        lvl_s[2] |=> sync_ready_n)
        else $error("sync ready went low in eisa burst mode");

    // eisa cycle cannot finish while ready return reads low
    AST_RTN_STALL: assert property (@(posedge local_bus_clock) disable iff (!reset_n)
        (s_q.st == HBH_SY_WAIT && lvl_s[2] && !rtn_fall_q) |=> s_q.st == HBH_SY_WAIT)
        else $error("eisa cycle finished without ready return high");

    // a vl completion is a one cycle low pulse
    AST_SRDY_PULSE: assert property (@(posedge local_bus_clock) disable iff (!reset_n)
        $fell(sync_ready_n) |=> sync_ready_n)
        else $error("sync ready low for more than one cycle");
endmodule
`default_nettype wire

// ===== hbh_host_port.sv
// host bus handshake, address decode and interrupt logic of the controller
`timescale 1ns/100ps
`default_nettype none
// Function
// - async ready release timed by core clock
// - async ready low on wait conditions
// - vl mode completion by synchronous falling edge
// - eisa cycle waits for ready return high
// - interrupt output is active high
// - select when qualifier low and address matches
// - select is unlatched combinational decode
// - data path select grants regardless of decode
// - data path accesses are full 32 bits
// - register decode only while qualifier low
// - mode select picks vl or eisa cycles
// - latch address and qualifier on strobe rise
module hbh_host_port (
    // core clock, derived from the crystal reference
    input  wire logic                             core_clk,
    input  wire logic                             reset_n,
    // local bus clock for synchronous modes
    input  wire logic                             local_bus_clock,
    // host address and qualifiers
    input  wire logic [hbh_pkg::ADDR_W-1:0]       upper_addr_lines,
    input  wire logic                             addr_qualifier,
    input  wire logic                             address_latch_strobe_n,
    input  wire logic [hbh_pkg::BE_W-1:0]         byte_lane_en_n,
    // host strobes and selects
    input  wire logic                             read_strobe_n,
    input  wire logic                             write_strobe_n,
    input  wire logic                             data_path_select_n,
    input  wire logic                             cycle_is_write,
    input  wire logic                             ready_return_n,
    input  wire logic                             vl_mode_select_n,
    // configuration from the core
    input  wire logic [hbh_pkg::BASE_W-1:0]       base_addr_high,
    input  wire logic                             no_wait_cfg,
    // fifo state from the core
    input  wire logic [hbh_pkg::FIFO_LVL_W-1:0]   rd_fifo_bytes,
    input  wire logic                             wr_fifo_full,
    // status event from the core
    input  wire logic                             status_event,
    // asynchronous ready, open drain
    output logic                                  async_ready_out,
    output logic                                  async_ready_oe_n,
    // synchronous ready
    output logic                                  sync_ready_n,
    // interrupt
    output logic                                  host_irq,
    // local device select
    output logic                                  local_device_sel_n,
    // access description to the core
    output logic                                  reg_access,
    output logic                                  data_path_grant,
    output logic [hbh_pkg::BE_W-1:0]              access_bytes,
    output logic [hbh_pkg::ADDR_W-1:0]            latched_addr
);
    import hbh_pkg::*;

    // all registered state of the core side
    typedef struct packed {
        logic              ads_prev;   // strobe level one cycle back
        logic [ADDR_W-1:0] addr_lat;   // address taken at strobe rise
        logic              qual_lat;   // qualifier taken at strobe rise
        logic              acc_prev;   // access active last cycle
        logic              async_ready_out_pull;  // holding the ready line low
        logic              reg_acc;    // register access in progress
        logic              dp_grant;   // data path access in progress
        logic [BE_W-1:0]   bytes;      // active lanes of this access
        logic              irq;        // interrupt output
    } hbh_core_state_t;

    hbh_core_state_t s_q;
    hbh_core_state_t s_d;

    // synchronised pin copies
    logic [PIN_SYNC_W-1:0] pin_s;
    logic                  ads_s;      // address strobe
    logic                  qual_s;     // address qualifier
    logic [ADDR_W-1:0]     addr_s;     // upper address lines
    logic                  rd_s;       // read strobe, active high here
    logic                  wr_s;       // write strobe, active high here
    logic                  dp_s;       // data path select, active high here
    logic [BE_W-1:0]       be_s;       // byte enables, active high here
    logic                  vl_s;       // mode select strap

    // decode helpers
    logic [ADDR_W-1:0]     base_match; // address the device answers to
    logic                  ads_rise;   // strobe rising this cycle
    logic                  hit_lat;    // latched register decode
    logic                  access;     // a selected strobe is active
    logic                  rd_wait;    // read must wait for data
    logic                  wr_wait;    // write must wait for room
    logic                  any_wait;   // some wait condition holds
    logic                  rd_ok;      // read could finish now
    logic                  wr_ok;      // write could finish now

    // host pins used on the core side pass two flops; select decode and local clock logic take raw pins
    // the strobes and selects idle high, so the bundle resets to ones
    hbh_sync2 #(.WIDTH(PIN_SYNC_W), .INIT_VAL(1'b1)) u_sync_pins (
        .clk      (core_clk),
        .reset_n  (reset_n),
        .async_in ({address_latch_strobe_n, addr_qualifier, upper_addr_lines,
                    read_strobe_n, write_strobe_n, data_path_select_n,
                    byte_lane_en_n, vl_mode_select_n}),
        .sync_out (pin_s)
    );

    // unpack the synchronised bundle
    assign ads_s  = pin_s[21];
    assign qual_s = pin_s[20];
    assign addr_s = pin_s[19:8];
    assign rd_s   = !pin_s[7];
    assign wr_s   = !pin_s[6];
    assign dp_s   = !pin_s[5];
    assign be_s   = ~pin_s[4:1];
    assign vl_s   = pin_s[0];

    // address the device answers to
    assign base_match = {base_addr_high, BASE_LOW_NIBBLE};

    // select output straight from the raw pins, no latch in the path
    // a latched copy would lag the host by a whole address phase
    assign local_device_sel_n = !(!addr_qualifier && (upper_addr_lines == base_match));

    // strobe rising edge marks the latching moment
    assign ads_rise = ads_s && !s_q.ads_prev;

    // register decode from the latched copy, only with qualifier low
    assign hit_lat = !s_q.qual_lat && (s_q.addr_lat == base_match);

    // data path select overrides every decode term
    assign access = (rd_s || wr_s) && (dp_s || hit_lat);

    // wait conditions of an asynchronous access
    assign rd_wait  = rd_s && (rd_fifo_bytes < RD_MIN_BYTES);
    assign wr_wait  = wr_s && wr_fifo_full;
    assign any_wait = !no_wait_cfg || rd_wait || wr_wait;

    // completion levels handed to the local clock logic
    assign rd_ok = no_wait_cfg && (rd_fifo_bytes >= RD_MIN_BYTES);
    assign wr_ok = no_wait_cfg && !wr_fifo_full;

    // next state of the core side
    always_comb begin
        s_d          = s_q;
        s_d.ads_prev = ads_s;
        // capture address and qualifier on the strobe rise
        if (ads_rise) begin
            s_d.addr_lat = addr_s;
            s_d.qual_lat = qual_s;
        end
        s_d.acc_prev = access;
        // pull ready low while a wait condition holds
        // the release follows on a core edge, so it is not tied to the host clock
        if (access && any_wait) begin
            s_d.async_ready_out_pull = 1'b1;
        end else begin
            s_d.async_ready_out_pull = 1'b0;
        end
        // describe the access to the packet path
        if (access && dp_s) begin
            s_d.dp_grant = 1'b1;
            s_d.reg_acc  = 1'b0;
            s_d.bytes    = BE_ALL;
        end else if (access) begin
            s_d.dp_grant = 1'b0;
            s_d.reg_acc  = 1'b1;
            s_d.bytes    = be_s;
        end else begin
            s_d.dp_grant = 1'b0;
            s_d.reg_acc  = 1'b0;
            s_d.bytes    = BE_NONE;
        end
        // interrupt follows the status event level, active high
        s_d.irq = status_event;
    end

    // registers of the core side
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '{ads_prev: 1'b1, addr_lat: '0, qual_lat: 1'b1, acc_prev: 1'b0,
                     async_ready_out_pull: 1'b0, reg_acc: 1'b0, dp_grant: 1'b0,
                     bytes: BE_NONE, irq: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // open drain: enable low drives the line low, else released
    assign async_ready_out  = 1'b0;
    assign async_ready_oe_n = !s_q.async_ready_out_pull;

    // registered outputs to the core and host
    assign host_irq        = s_q.irq;
    assign reg_access      = s_q.reg_acc;
    assign data_path_grant = s_q.dp_grant;
    assign access_bytes    = s_q.bytes;
    assign latched_addr    = s_q.addr_lat;

    // synchronous ready runs on the local bus clock
    // the host keeps that clock within its limits, or high in async mode
    hbh_local_bus_clock_ready u_local_bus_clock_ready (
        .local_bus_clock        (local_bus_clock),
        .reset_n                (reset_n),
        .address_latch_strobe_n (address_latch_strobe_n),
        .cycle_sel_n            (local_device_sel_n && data_path_select_n),
        .cycle_is_write         (cycle_is_write),
        .ready_return_n         (ready_return_n),
        .vl_mode_select_n       (vl_mode_select_n),
        .core_rd_ok             (rd_ok),
        .core_wr_ok             (wr_ok),
        .sync_ready_n           (sync_ready_n)
    );

    // select follows a matching unlatched address at once
    AST_SEL_MATCH: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!addr_qualifier && upper_addr_lines == base_match) |-> !local_device_sel_n)
        else $error("select not asserted on matching address");

    // qualifier high blocks the select
    AST_SEL_QUAL: assert property (@(posedge core_clk) disable iff (!reset_n)
        addr_qualifier |-> local_device_sel_n)
        else $error("select asserted with qualifier high");

    // latched decode ignores an address seen with qualifier high
    AST_DECODE_QUAL: assert property (@(posedge core_clk) disable iff (!reset_n)
        (s_q.qual_lat && !dp_s) |=> !s_q.reg_acc)
        else $error("register access with qualifier high");

    // address captured on the strobe rise
    AST_LATCH: assert property (@(posedge core_clk) disable iff (!reset_n)
        ads_rise |=> (s_q.addr_lat == $past(addr_s) && s_q.qual_lat == $past(qual_s)))
        else $error("address not latched on strobe rise");

    // data path access is granted with all four lanes
    AST_DP_FULL: assert property (@(posedge core_clk) disable iff (!reset_n)
        ((rd_s || wr_s) && dp_s) |=> (s_q.dp_grant && s_q.bytes == BE_ALL))
        else $error("data path access not full width");

    // ready pulled low one cycle after a wait condition
    AST_ASYNC_READY_OUT_WAIT: assert property (@(posedge core_clk) disable iff (!reset_n)
        (access && !no_wait_cfg) |=> !async_ready_oe_n)
        else $error("ready not pulled on wait condition");

    // ready left released when nothing asks for a wait
    AST_ASYNC_READY_OUT_FREE: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!access || !any_wait) |=> async_ready_oe_n)
        else $error("ready pulled with no wait condition");

    // interrupt tracks the status event one cycle later
    AST_IRQ: assert property (@(posedge core_clk) disable iff (!reset_n)
        status_event |=> host_irq ##0 $past(status_event, 1))
        else $error("interrupt not raised on status event");

    // a short read fifo holds the ready line low
    AST_ASYNC_READY_OUT_RD: assert property (@(posedge core_clk) disable iff (!reset_n)
        (access && rd_wait) |=> !async_ready_oe_n)
        else $error("ready released on short read fifo");

    // a full write fifo holds the ready line low
    AST_ASYNC_READY_OUT_WR: assert property (@(posedge core_clk) disable iff (!reset_n)
        (access && wr_wait) |=> !async_ready_oe_n)
        else $error("ready released on full write fifo");

    // release lands on the core edge after the wait clears
    AST_ASYNC_READY_OUT_DONE: assert property (@(posedge core_clk) disable iff (!reset_n)
        (access && !any_wait) |=> async_ready_oe_n)
        else $error("ready held after wait cleared");

    // no decode, no access reported to the core
    AST_NO_ACCESS: assert property (@(posedge core_clk) disable iff (!reset_n)
        !access |=> (!reg_access && !data_path_grant))
        else $error("access reported without decode");

    // idle lanes while nothing is selected
    AST_LANES_IDLE: assert property (@(posedge core_clk) disable iff (!reset_n)
        !access |=> access_bytes == BE_NONE)
        else $error("lanes active without access");

    // byte enables only shape register accesses
    AST_REG_LANES: assert property (@(posedge core_clk) disable iff (!reset_n)
        (access && !dp_s) |=> access_bytes == $past(be_s))
        else $error("register lanes differ from byte enables");

    // data path select wins over the register decode
    AST_DP_OVERRIDE: assert property (@(posedge core_clk) disable iff (!reset_n)
        ((rd_s || wr_s) && dp_s) |=> !reg_access)
        else $error("register access under data path select");

    // latched copy moves only on a strobe rise
    AST_LATCH_HOLD: assert property (@(posedge core_clk) disable iff (!reset_n)
        !ads_rise |=> $stable(latched_addr))
        else $error("latched address moved without strobe rise");

    // any other address leaves the select high
    AST_SEL_MISS: assert property (@(posedge core_clk) disable iff (!reset_n)
        (upper_addr_lines != base_match) |-> local_device_sel_n)
        else $error("select asserted on other address");

    // no status event, no interrupt
    AST_IRQ_LOW: assert property (@(posedge core_clk) disable iff (!reset_n)
        !status_event |=> !host_irq)
        else $error("interrupt high without status event");
endmodule
`default_nettype wire

// ===== hbh_host_model.sv
// host side model: local bus clock and synchronous bus cycles
`timescale 1ns/100ps
`default_nettype none
module hbh_host_model (
    // control from the bench
    input  wire logic local_bus_clock_run,
    input  wire logic tb_ads_n,
    // answer from the device
    input  wire logic sync_ready_n,
    // pins toward the device
    output logic      local_bus_clock,
    output logic      address_latch_strobe_n,
    output logic      cycle_is_write,
    output logic      ready_return_n
);
    logic cyc_ads_n;    // strobe of a synchronous cycle
    // bench strobe and cycle strobe share one pin
    assign address_latch_strobe_n = tb_ads_n & cyc_ads_n;
    // 8 MHz clock, parked high while the bus is asynchronous
    initial begin
        local_bus_clock = 1'b1;
        cyc_ads_n = 1'b1;
        cycle_is_write = 1'b0;
        ready_return_n = 1'b0;
        #3.7;
        forever begin
            #62.5;
            local_bus_clock = local_bus_clock_run ? ~local_bus_clock : 1'b1;
        end
    end
    // maybe start a cycle, then count low ready cycles over a window
    task automatic run_cycle(input logic go, input logic wr, input int win, output int lows);
        int n;
        lows = 0;
        @(posedge local_bus_clock);
        #1;
        cyc_ads_n = ~go;
        cycle_is_write = wr;
        for (n = 0; n < win; n++) begin
            @(negedge local_bus_clock);
            #1;
            ready_return_n = (n >= win / 2); // return held low, then high
            @(posedge local_bus_clock);
            #1;
            cyc_ads_n = 1'b1;
            if (sync_ready_n === 1'b0) lows++;
        end
        ready_return_n = 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== tb_hbh_host_port.sv
// self-checking bench for the host bus handshake block
`timescale 1ns/100ps
`default_nettype none
module tb_hbh_host_port;
    import hbh_pkg::*;
    // clocks, reset and host pins
    logic                  core_clk, reset_n, local_bus_clock_run, tb_ads_n, local_bus_clock;
    logic                  address_latch_strobe_n, cycle_is_write, ready_return_n;
    logic                  addr_qualifier, read_strobe_n, write_strobe_n, data_path_select_n;
    logic                  vl_mode_select_n, no_wait_cfg, wr_fifo_full, status_event;
    logic [ADDR_W-1:0]     upper_addr_lines, latched_addr;
    logic [BE_W-1:0]       byte_lane_en_n, access_bytes;
    logic [BASE_W-1:0]     base_addr_high;
    logic [FIFO_LVL_W-1:0] rd_fifo_bytes;
    // device outputs
    logic                  async_ready_out, async_ready_oe_n, sync_ready_n, host_irq;
    logic                  local_device_sel_n, reg_access, data_path_grant, ard_wire;
    int                    errors, compares;
    // open drain line with pull-up
    assign ard_wire = async_ready_oe_n ? 1'b1 : async_ready_out;
    hbh_host_port hbh_host_port_i (.core_clk, .reset_n, .local_bus_clock, .upper_addr_lines,
        .addr_qualifier, .address_latch_strobe_n, .byte_lane_en_n, .read_strobe_n,
        .write_strobe_n, .data_path_select_n, .cycle_is_write, .ready_return_n,
        .vl_mode_select_n, .base_addr_high, .no_wait_cfg, .rd_fifo_bytes, .wr_fifo_full,
        .status_event, .async_ready_out, .async_ready_oe_n, .sync_ready_n, .host_irq,
        .local_device_sel_n, .reg_access, .data_path_grant, .access_bytes, .latched_addr);
    hbh_host_model hbh_host_model_i (.local_bus_clock_run, .tb_ads_n, .sync_ready_n, .local_bus_clock,
        .address_latch_strobe_n, .cycle_is_write, .ready_return_n);
    // 100 MHz core clock
    always #5 core_clk = ~core_clk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // inputs change 1 ns after the edge
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic close_out;
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // pulse the address strobe to latch the present pins
    task automatic latch(input logic [12:0] qa);
        {addr_qualifier, upper_addr_lines} = qa;
        tb_ads_n = 1'b0;
        step(4);
        tb_ads_n = 1'b1;
        step(4);
    endtask
    task automatic t_decode;
        logic [12:0] cases [5] = '{13'h0a50, 13'h1a50, 13'h0a51, 13'h0b50, 13'h0a58};
        int i;
        for (i = 0; i < 5; i++) begin
            {addr_qualifier, upper_addr_lines} = cases[i];
            step(1);
            chk(local_device_sel_n, i != 0);
        end
    endtask
    task automatic t_latch;
        tb_ads_n = 1'b0;
        {addr_qualifier, upper_addr_lines} = 13'h0a50;
        step(1);
        chk(local_device_sel_n, 1'b0);
        latch(13'h0a50);
        chk(latched_addr, 12'ha50);
        {addr_qualifier, upper_addr_lines} = 13'h03c0;
        step(1);
        chk(local_device_sel_n, 1'b1);
        step(3);
        chk(latched_addr, 12'ha50);
    endtask
    // status event level reaches the interrupt one cycle later
    task automatic t_irq;
        status_event = 1'b1;
        step(1);
        chk(host_irq, 1'b1);
        status_event = 1'b0;
        step(1);
        chk(host_irq, 1'b0);
    endtask
    // one async access; exp is {ready line, register access, data path grant}
    task automatic t_async(input logic rd, nw, full, dps, input logic [3:0] lvl,
                           input logic [2:0] exp);
        no_wait_cfg = nw;
        rd_fifo_bytes = lvl;
        wr_fifo_full = full;
        data_path_select_n = dps;
        read_strobe_n = ~rd;
        write_strobe_n = rd;
        step(5);
        chk({ard_wire, reg_access, data_path_grant}, exp);
        if (!dps) chk(access_bytes, BE_ALL);
        no_wait_cfg = 1'b1;
        rd_fifo_bytes = 4'h8;
        wr_fifo_full = 1'b0;
        step(4);
        chk(ard_wire, 1'b1);
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        data_path_select_n = 1'b1;
        step(5);
        chk({ard_wire, reg_access, data_path_grant}, 3'b100);
    endtask
    task automatic t_sync(input logic vl_n, input int exp);
        int lows;
        vl_mode_select_n = vl_n;
        data_path_select_n = 1'b0;
        rd_fifo_bytes = 4'h3;
        local_bus_clock_run = 1'b1;
        hbh_host_model_i.run_cycle(1'b1, 1'b0, 8, lows);
        chk(16'(lows), 16'h0);
        step(1);
        rd_fifo_bytes = 4'h8;
        hbh_host_model_i.run_cycle(1'b0, 1'b0, 8, lows);
        chk(16'(lows), 16'(exp));
        hbh_host_model_i.run_cycle(1'b1, 1'b1, 8, lows);
        chk(16'(lows), 16'(exp));
        step(1);
        local_bus_clock_run = 1'b0;
        data_path_select_n = 1'b1;
    endtask
    // hang guard
    initial begin
        #900000;
        errors++;
        close_out;
    end
    initial begin
        {core_clk, reset_n, local_bus_clock_run, tb_ads_n, addr_qualifier} = 5'b00011;
        {read_strobe_n, write_strobe_n, data_path_select_n, vl_mode_select_n} = 4'hf;
        {no_wait_cfg, wr_fifo_full, status_event} = 3'b100;
        upper_addr_lines = 12'h000;
        byte_lane_en_n = 4'h1;
        base_addr_high = 8'ha5;
        rd_fifo_bytes = 4'h8;
        errors = 0;
        compares = 0;
        step(6);
        reset_n = 1'b1;
        step(2);
        chk({async_ready_oe_n, sync_ready_n, host_irq, reg_access,
             data_path_grant}, 5'h18);
        chk({access_bytes, latched_addr}, 16'h0);
        t_decode;
        t_latch;
        t_irq;
        t_async(1'b1, 1'b1, 1'b0, 1'b1, 4'h8, 3'b110);
        t_async(1'b0, 1'b0, 1'b0, 1'b1, 4'h8, 3'b010);
        latch(13'h1a50);
        t_async(1'b1, 1'b0, 1'b0, 1'b1, 4'h8, 3'b100);
        t_async(1'b1, 1'b0, 1'b0, 1'b0, 4'h8, 3'b001);
        t_async(1'b1, 1'b1, 1'b0, 1'b0, 4'h3, 3'b001);
        t_async(1'b1, 1'b1, 1'b0, 1'b0, 4'h4, 3'b101);
        t_async(1'b0, 1'b1, 1'b1, 1'b0, 4'h0, 3'b001);
        t_async(1'b0, 1'b1, 1'b0, 1'b0, 4'h0, 3'b101);
        t_sync(1'b0, 1);
        t_sync(1'b1, 0);
        close_out;
    end
endmodule
`default_nettype wire
